// ==== verilog/usr_defs.vh ====
`ifndef USR_DEFS_VH
`define USR_DEFS_VH

// Register indices; byte address is four times the index
`define USR_IDX_FLAGS   8'h10
`define USR_IDX_ENABLES 8'h11
`define USR_IDX_RECEIVE_STATUS_REGISTER   8'h13
`define USR_IDX_RCDATA  8'h14
`define USR_IDX_TRANSMIT_STATUS_REGISTER   8'h15
`define USR_IDX_TXHOLD  8'h16
`define USR_IDX_BAUD    8'h17

// Receive status/control field positions
`define USR_RC_SERIAL_PORT_ENABLE  7
`define USR_RC_RX9   6
`define USR_RC_SINGLE_WORD_RECEIVE_ENABLE  5
`define USR_RC_CONTINUOUS_RECEIVE_ENABLE  4
`define USR_RC_FRAMING_ERROR_BIT  2
`define USR_RC_OVERRUN_ERROR_BIT  1
`define USR_RC_RECEIVED_NINTH_BIT  0

// Transmit status/control field positions
`define USR_TX_CLOCK_SOURCE_SELECT  7
`define USR_TX_TX9   6
`define USR_TX_TRANSMIT_ENABLE  5
`define USR_TX_SYNC  4
`define USR_TX_TRMT  1
`define USR_TX_TRANSMIT_NINTH_BIT  0

// Flag and enable field positions
`define USR_FL_TX    1
`define USR_FL_RC    0

// Reset values and sizes
`define USR_ZERO8    8'h00
`define USR_ZERO32   32'h0000_0000
`define USR_BITS8    4'h8
`define USR_BITS9    4'h9
`define USR_ONE4     4'h1
`define USR_ONE8     8'h01
`define USR_FIFO_CNT 2'h2
`define USR_HTRANS_NONSEQ_BIT 1

`endif

// ==== verilog/usr_sync_port.v ====
// Contract
// - With sync mode set, reception starts when single or continuous enable is set; here single enable starts it only with clock source set (master).
// - Data line is sampled on every falling shift clock edge while receiving.
// - Single enable takes one word; continuous runs until software clears it.
// - Both enables set behaves as continuous reception.
// - Last bit moves the word into the FIFO if room, then receive-ready sets.
// - Receive-ready is read-only; clears when data register read and empty.
// - Receive interrupt request only with its enable; flag sets regardless.
// - Receive data is a two-entry FIFO; a third word may be shifting.
// - FIFO full at a word's last bit sets overrun and drops that word.
// - Overrun clears only when software clears continuous enable.
// - While overrun is set, no word moves from shift register to FIFO.
// - Ninth bit and framing status queue per word; data read advances them.
// - Clearing both receive enables or port enable idles the receive logic.
// - Master mode drives shift clock; clock-source clear takes it from pin.
// - Slave mode keeps shifting while the core sleeps.
// - Slave mode: first word goes to shift register at once, second waits.
// - After first word shifts out, second moves in and transmit-empty sets.
// - Clearing port or transmit enable stops and resets transmit logic.
// - Sync bit selects synchronous mode; port enable gives pins to the port.
// - Baud generator held in reset while transmit and both receive enables clear.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
`include "usr_defs.vh"

module usr_sync_port (
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        core_sleep,
    input  wire        shift_clock_pin_i,
    output wire        shift_clock_pin_o,
    output wire        shift_clock_pin_oe,
    input  wire        data_line_pin_i,
    output wire        data_line_pin_o,
    output wire        data_line_pin_oe,
    output wire        rx_irq_req,
    output wire        tx_irq_req
);

    localparam TXS_IDLE  = 1'b0;
    localparam TXS_SHIFT = 1'b1;

    // Control bits
    reg        serial_port_enable_ff;
    reg        rx9_ff;
    reg        single_word_receive_enable_ff;
    reg        continuous_receive_enable_ff;
    reg        overrun_error_bit_ff;
    reg        clock_source_select_ff;
    reg        tx9_ff;
    reg        transmit_enable_ff;
    reg        sync_ff;
    reg        transmit_ninth_bit_ff;
    reg  [7:0] baud_ff;
    reg        receive_interrupt_enable_ff;
    reg        transmit_interrupt_enable_ff;
    // Bus slave
    reg        ap_valid_ff;
    reg        ap_write_ff;
    reg  [7:0] ap_idx_ff;
    reg        hready_ff;
    reg [31:0] hrdata_ff;
    reg        hresp_ff;
    // Clocking
    reg  [7:0] brg_cnt_ff;
    reg        ck_int_ff;
    reg        sclk_prev_ff;
    // Receive path
    reg  [8:0] rsr_ff;
    reg  [3:0] rcnt_ff;
    reg        wptr_ff;
    reg        rptr_ff;
    reg  [1:0] fcnt_ff;
    // Transmit path
    reg  [7:0] thr_ff;
    reg        thr_full_ff;
    reg  [8:0] tsr_ff;
    reg  [3:0] tcnt_ff;
    reg        tx_state_ff;
    reg        tdo_ff;
    // Pin and request outputs
    reg        ck_oe_ff;
    reg        dt_oe_ff;
    reg        rx_irq_ff;
    reg        tx_irq_ff;

    reg  [8:0] nxt_rx_word;
    reg [31:0] nxt_hrdata;

    // Register hit in the data phase
    function hit;
        input [7:0] idx;
        input [7:0] want;
        begin
            hit = (idx == want);
        end
    endfunction

    wire acc      = ap_valid_ff;
    wire wr_receive_status_register = acc & ap_write_ff & hit(ap_idx_ff, `USR_IDX_RECEIVE_STATUS_REGISTER);
    wire wr_transmit_status_register = acc & ap_write_ff & hit(ap_idx_ff, `USR_IDX_TRANSMIT_STATUS_REGISTER);
    wire wr_thr   = acc & ap_write_ff & hit(ap_idx_ff, `USR_IDX_TXHOLD);
    wire wr_ena   = acc & ap_write_ff & hit(ap_idx_ff, `USR_IDX_ENABLES);
    wire wr_baud  = acc & ap_write_ff & hit(ap_idx_ff, `USR_IDX_BAUD);
    wire rd_data  = acc & ~ap_write_ff & hit(ap_idx_ff, `USR_IDX_RCDATA);

    wire rx_en    = sync_ff & serial_port_enable_ff & (continuous_receive_enable_ff | (single_word_receive_enable_ff & clock_source_select_ff));
    wire tx_on    = serial_port_enable_ff & transmit_enable_ff;
    wire tx_drive = sync_ff & tx_on & ~rx_en;
    wire trmt     = (tx_state_ff == TXS_IDLE);
    wire brg_hold = ~(transmit_enable_ff | single_word_receive_enable_ff | continuous_receive_enable_ff);
    wire brg_tick = (brg_cnt_ff == `USR_ZERO8);
    wire clk_run  = sync_ff & serial_port_enable_ff & clock_source_select_ff & (rx_en | ~trmt);
    wire sclk     = clock_source_select_ff ? ck_int_ff : shift_clock_pin_i;
    wire sfall    = sclk_prev_ff & ~sclk;
    wire srise    = ~sclk_prev_ff & sclk;
    wire [3:0] rbits  = rx9_ff ? `USR_BITS9 : `USR_BITS8;
    wire       rx_last = rx_en & sfall & (rcnt_ff == rbits - `USR_ONE4);
    wire       ffull   = (fcnt_ff == `USR_FIFO_CNT);
    wire       fempty  = (fcnt_ff == 2'h0);
    wire       push    = rx_last & ~overrun_error_bit_ff & ~ffull;
    wire       pop     = rd_data & ~fempty;

    // Bus address phase capture; one wait state makes read data a flop
    always @(posedge mclk) begin
        if (!rst_n) begin
            ap_valid_ff <= 1'b0;
            ap_write_ff <= 1'b0;
            ap_idx_ff   <= `USR_ZERO8;
            hready_ff   <= 1'b1;
            hrdata_ff   <= `USR_ZERO32;
            hresp_ff    <= 1'b0;
        end else begin
            hresp_ff <= 1'b0;
            if (ap_valid_ff) begin
                ap_valid_ff <= 1'b0;
                hready_ff   <= 1'b1;
                hrdata_ff   <= ap_write_ff ? `USR_ZERO32 : nxt_hrdata;
            end else if (hsel & htrans[`USR_HTRANS_NONSEQ_BIT] & hready) begin
                ap_valid_ff <= 1'b1;
                ap_write_ff <= hwrite;
                ap_idx_ff   <= haddr[9:2];
                hready_ff   <= 1'b0;
            end
        end
    end

    // FIFO entries: framing_error_bit, ninth bit, data
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_ent
            reg [9:0] ent_ff;
            always @(posedge mclk) begin
                if (!rst_n) begin
                    ent_ff <= 10'h000;
                end else if (push & (wptr_ff == gi)) begin
                    ent_ff <= {1'b0, rx9_ff & nxt_rx_word[8], nxt_rx_word[7:0]};
                end
            end
        end
    endgenerate

    wire [9:0] head = rptr_ff ? g_ent[1].ent_ff : g_ent[0].ent_ff;

    // Read mux; unmapped addresses read zero
    always @* begin
        nxt_hrdata = `USR_ZERO32;
        case (ap_idx_ff)
            `USR_IDX_FLAGS: begin
                nxt_hrdata[`USR_FL_TX] = ~thr_full_ff;
                nxt_hrdata[`USR_FL_RC] = ~fempty;
            end
            `USR_IDX_ENABLES: begin
                nxt_hrdata[`USR_FL_TX] = transmit_interrupt_enable_ff;
                nxt_hrdata[`USR_FL_RC] = receive_interrupt_enable_ff;
            end
            `USR_IDX_RECEIVE_STATUS_REGISTER: begin
                nxt_hrdata[`USR_RC_SERIAL_PORT_ENABLE] = serial_port_enable_ff;
                nxt_hrdata[`USR_RC_RX9]  = rx9_ff;
                nxt_hrdata[`USR_RC_SINGLE_WORD_RECEIVE_ENABLE] = single_word_receive_enable_ff;
                nxt_hrdata[`USR_RC_CONTINUOUS_RECEIVE_ENABLE] = continuous_receive_enable_ff;
                nxt_hrdata[`USR_RC_FRAMING_ERROR_BIT] = head[9];
                nxt_hrdata[`USR_RC_OVERRUN_ERROR_BIT] = overrun_error_bit_ff;
                nxt_hrdata[`USR_RC_RECEIVED_NINTH_BIT] = head[8];
            end
            `USR_IDX_RCDATA: nxt_hrdata[7:0] = head[7:0];
            `USR_IDX_TRANSMIT_STATUS_REGISTER: begin
                nxt_hrdata[`USR_TX_CLOCK_SOURCE_SELECT] = clock_source_select_ff;
                nxt_hrdata[`USR_TX_TX9]  = tx9_ff;
                nxt_hrdata[`USR_TX_TRANSMIT_ENABLE] = transmit_enable_ff;
                nxt_hrdata[`USR_TX_SYNC] = sync_ff;
                nxt_hrdata[`USR_TX_TRMT] = trmt;
                nxt_hrdata[`USR_TX_TRANSMIT_NINTH_BIT] = transmit_ninth_bit_ff;
            end
            `USR_IDX_TXHOLD: nxt_hrdata[7:0] = thr_ff;
            `USR_IDX_BAUD:   nxt_hrdata[7:0] = baud_ff;
            default:         nxt_hrdata = `USR_ZERO32;
        endcase
    end

    // Control registers; hardware clear of single enable and overrun set win
    always @(posedge mclk) begin
        if (!rst_n) begin
            serial_port_enable_ff <= 1'b0;
            rx9_ff  <= 1'b0;
            single_word_receive_enable_ff <= 1'b0;
            continuous_receive_enable_ff <= 1'b0;
            overrun_error_bit_ff <= 1'b0;
            clock_source_select_ff <= 1'b0;
            tx9_ff  <= 1'b0;
            transmit_enable_ff <= 1'b0;
            sync_ff <= 1'b0;
            transmit_ninth_bit_ff <= 1'b0;
            baud_ff <= `USR_ZERO8;
            receive_interrupt_enable_ff <= 1'b0;
            transmit_interrupt_enable_ff <= 1'b0;
        end else begin
            if (wr_receive_status_register) begin
                serial_port_enable_ff <= hwdata[`USR_RC_SERIAL_PORT_ENABLE];
                rx9_ff  <= hwdata[`USR_RC_RX9];
                single_word_receive_enable_ff <= hwdata[`USR_RC_SINGLE_WORD_RECEIVE_ENABLE];
                continuous_receive_enable_ff <= hwdata[`USR_RC_CONTINUOUS_RECEIVE_ENABLE];
                if (!hwdata[`USR_RC_CONTINUOUS_RECEIVE_ENABLE])
                    overrun_error_bit_ff <= 1'b0;
            end
            if (rx_last & ffull & ~overrun_error_bit_ff)
                overrun_error_bit_ff <= 1'b1;
            if (rx_last & single_word_receive_enable_ff & ~continuous_receive_enable_ff)
                single_word_receive_enable_ff <= 1'b0;
            if (wr_transmit_status_register) begin
                clock_source_select_ff <= hwdata[`USR_TX_CLOCK_SOURCE_SELECT];
                tx9_ff  <= hwdata[`USR_TX_TX9];
                transmit_enable_ff <= hwdata[`USR_TX_TRANSMIT_ENABLE];
                sync_ff <= hwdata[`USR_TX_SYNC];
                transmit_ninth_bit_ff <= hwdata[`USR_TX_TRANSMIT_NINTH_BIT];
            end
            if (wr_baud)
                baud_ff <= hwdata[7:0];
            if (wr_ena) begin
                transmit_interrupt_enable_ff <= hwdata[`USR_FL_TX];
                receive_interrupt_enable_ff <= hwdata[`USR_FL_RC];
            end
        end
    end

    // Baud generator; master clock halts with the core clock in sleep
    always @(posedge mclk) begin
        if (!rst_n) begin
            brg_cnt_ff <= `USR_ZERO8;
            ck_int_ff  <= 1'b0;
        end else begin
            if (brg_hold)
                brg_cnt_ff <= baud_ff;
            else if (!core_sleep)
                brg_cnt_ff <= brg_tick ? baud_ff : brg_cnt_ff - `USR_ONE8;
            if (!clk_run)
                ck_int_ff <= 1'b0;
            else if (!brg_hold & !core_sleep & brg_tick)
                ck_int_ff <= ~ck_int_ff;
        end
    end

    // Edge detect on the chosen shift clock; slave path needs no core clock gate
    always @(posedge mclk) begin
        if (!rst_n)
            sclk_prev_ff <= 1'b0;
        else
            sclk_prev_ff <= sclk;
    end

    // Word as it stands with the bit sampled this edge
    always @* begin
        nxt_rx_word = rsr_ff;
        nxt_rx_word[rcnt_ff] = data_line_pin_i;
    end

    // Receive shifter; dropping enables returns it to bit zero
    always @(posedge mclk) begin
        if (!rst_n) begin
            rsr_ff  <= 9'h000;
            rcnt_ff <= 4'h0;
        end else if (!rx_en) begin
            rsr_ff  <= 9'h000;
            rcnt_ff <= 4'h0;
        end else if (sfall) begin
            rsr_ff  <= nxt_rx_word;
            rcnt_ff <= rx_last ? 4'h0 : rcnt_ff + `USR_ONE4;
        end
    end

    // FIFO pointers; a pop of the last word drops receive-ready
    always @(posedge mclk) begin
        if (!rst_n) begin
            wptr_ff <= 1'b0;
            rptr_ff <= 1'b0;
            fcnt_ff <= 2'h0;
        end else begin
            if (push)
                wptr_ff <= ~wptr_ff;
            if (pop)
                rptr_ff <= ~rptr_ff;
            if (push & ~pop)
                fcnt_ff <= fcnt_ff + 2'h1;
            else if (pop & ~push)
                fcnt_ff <= fcnt_ff - 2'h1;
        end
    end

    // Transmit holding register; a write in the move cycle keeps it full
    always @(posedge mclk) begin
        if (!rst_n) begin
            thr_ff      <= `USR_ZERO8;
            thr_full_ff <= 1'b0;
        end else begin
            if (tx_on & trmt & thr_full_ff)
                thr_full_ff <= 1'b0;
            if (wr_thr) begin
                thr_ff      <= hwdata[7:0];
                thr_full_ff <= 1'b1;
            end
        end
    end

    // Transmit shifter: bit out on rising edge, idle after last falling edge
    always @(posedge mclk) begin
        if (!rst_n) begin
            tsr_ff      <= 9'h000;
            tcnt_ff     <= 4'h0;
            tx_state_ff <= TXS_IDLE;
            tdo_ff      <= 1'b0;
        end else if (!tx_on) begin
            tcnt_ff     <= 4'h0;
            tx_state_ff <= TXS_IDLE;
            tdo_ff      <= 1'b0;
        end else begin
            case (tx_state_ff)
                TXS_IDLE: begin
                    if (thr_full_ff) begin
                        tsr_ff      <= {transmit_ninth_bit_ff, thr_ff};
                        tcnt_ff     <= tx9_ff ? `USR_BITS9 : `USR_BITS8;
                        tx_state_ff <= TXS_SHIFT;
                    end
                end
                TXS_SHIFT: begin
                    if (tx_drive & srise & (tcnt_ff != 4'h0)) begin
                        tdo_ff  <= tsr_ff[0];
                        tsr_ff  <= {1'b0, tsr_ff[8:1]};
                        tcnt_ff <= tcnt_ff - `USR_ONE4;
                    end else if (tx_drive & sfall & (tcnt_ff == 4'h0)) begin
                        tx_state_ff <= TXS_IDLE;
                    end
                end
                default: tx_state_ff <= TXS_IDLE;
            endcase
        end
    end

    // Pin enables and interrupt requests, registered
    always @(posedge mclk) begin
        if (!rst_n) begin
            ck_oe_ff  <= 1'b0;
            dt_oe_ff  <= 1'b0;
            rx_irq_ff <= 1'b0;
            tx_irq_ff <= 1'b0;
        end else begin
            ck_oe_ff  <= sync_ff & serial_port_enable_ff & clock_source_select_ff;
            dt_oe_ff  <= tx_drive;
            rx_irq_ff <= ~fempty & receive_interrupt_enable_ff;
            tx_irq_ff <= ~thr_full_ff & transmit_interrupt_enable_ff;
        end
    end

    assign hrdata             = hrdata_ff;
    assign hreadyout          = hready_ff;
    assign hresp              = hresp_ff;
    assign shift_clock_pin_o  = ck_int_ff;
    assign shift_clock_pin_oe = ck_oe_ff;
    assign data_line_pin_o    = tdo_ff;
    assign data_line_pin_oe   = dt_oe_ff;
    assign rx_irq_req         = rx_irq_ff;
    assign tx_irq_req         = tx_irq_ff;

endmodule // usr_sync_port
`default_nettype wire

// ==== dv/usr_sync_port_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module usr_sync_port_assertions (
    input wire logic        mclk,
    input wire logic        rst_n,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        shift_clock_pin_o,
    input wire logic        shift_clock_pin_oe,
    input wire logic        data_line_pin_oe,
    input wire logic        rx_irq_req,
    input wire logic        tx_irq_req
);
    logic       pend_ff;
    logic [7:0] idx_ff;
    logic [7:0] rc_ff;
    logic [7:0] tx_ff;
    logic [1:0] ie_ff;
    logic       en;
    logic       mst;
    assign en = tx_ff[5] | rc_ff[5] | rc_ff[4];
    assign mst = rc_ff[7] & tx_ff[7] & tx_ff[4];
    // Shadow of the control bits; hardware clearing of single receive only makes it conservative
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            pend_ff <= 1'b0;
            idx_ff <= 8'h00;
            rc_ff <= 8'h00;
            tx_ff <= 8'h00;
            ie_ff <= 2'h0;
        end else begin
            pend_ff <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready) idx_ff <= haddr[9:2];
            if (pend_ff && idx_ff == 8'h13) rc_ff <= hwdata[7:0];
            if (pend_ff && idx_ff == 8'h15) tx_ff <= hwdata[7:0];
            if (pend_ff && idx_ff == 8'h11) ie_ff <= hwdata[1:0];
        end
    end
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_n);
    sequence s_take;
        hsel && htrans[1] && hready;
    endsequence
    sequence s_one_wait;
        !hreadyout ##1 hreadyout;
    endsequence
    AST_BUS_WAIT: assert property (s_take |=> s_one_wait)
        else $error("bus wait state is not exactly one cycle");
    AST_RX_IRQ: assert property (rx_irq_req |-> $past(ie_ff[0]))
        else $error("receive request without its enable");
    AST_TX_IRQ: assert property (tx_irq_req |-> $past(ie_ff[1]))
        else $error("transmit request without its enable");
    AST_SLAVE_CLK: assert property (!tx_ff[7] && !$past(tx_ff[7]) |-> !shift_clock_pin_oe)
        else $error("clock pin driven in slave mode");
    AST_MASTER_CLK: assert property (mst && $past(mst) |-> shift_clock_pin_oe)
        else $error("clock pin not driven in master mode");
    AST_BAUD_IDLE: assert property (!en && !$past(en) |-> !$rose(shift_clock_pin_o))
        else $error("shift clock runs with all enables clear");
    AST_TX_STOP: assert property (!tx_ff[5] && !$past(tx_ff[5]) |-> !data_line_pin_oe)
        else $error("data pin driven with transmit disabled");
    AST_RX_QUIET: assert property (rc_ff[4] && $past(rc_ff[4]) |-> !data_line_pin_oe)
        else $error("data pin driven during continuous receive");
endmodule // usr_sync_port_assertions
`default_nettype wire

// ==== dv/usr_far_end.sv ====
`timescale 1ns/100ps
`default_nettype none
module usr_far_end (
    input  wire logic        mclk,
    input  wire logic        sclk_in,
    input  wire logic        dl_in,
    input  wire logic        drive,
    input  wire logic [36:0] stream,
    input  wire logic        go,
    input  wire logic [3:0]  nbits,
    output var  logic        sclk_out,
    output var  logic        dl_out,
    output var  logic [8:0]  got,
    output var  logic        busy
);
    logic        sclk_d_ff;
    logic        alt_ff = 1'b0;
    logic [36:0] sh_ff;
    logic [2:0]  cnt_ff;
    logic [4:0]  edg_ff;
    initial sclk_out = 1'b0;
    initial busy = 1'b0;
    // Released line toggles every cycle so a stale level never passes for data
    always_comb dl_out = drive ? sh_ff[0] : alt_ff;
    // Stream moves on the port's rising clock so each bit stands across the sampling fall
    always @(posedge mclk) begin
        sclk_d_ff <= sclk_in;
        alt_ff <= ~alt_ff;
        if (!drive) begin
            sh_ff <= stream;
        end else if (sclk_in && !sclk_d_ff) begin
            sh_ff <= sh_ff >> 1;
        end
    end
    // Slave clock of four cycles a half; it rests low between frames
    always @(posedge mclk) begin
        if (!busy) begin
            cnt_ff <= 3'h0;
            edg_ff <= 5'h0;
            busy <= go;
        end else begin
            cnt_ff <= cnt_ff + 3'h1;
            if (cnt_ff == 3'h3) begin
                cnt_ff <= 3'h0;
                sclk_out <= ~sclk_out;
                edg_ff <= edg_ff + 5'h1;
                if (sclk_out) got <= {dl_in, got[8:1]};
                if (edg_ff == {nbits, 1'b0} - 5'h1) busy <= 1'b0;
            end
        end
    end
endmodule // usr_far_end
`default_nettype wire

// ==== dv/test_usr_sync_port.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "usr_defs.vh"
module test_usr_sync_port;
    logic        mclk;
    logic        rst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        core_sleep;
    logic        drive;
    logic [36:0] stream;
    logic        go;
    logic [3:0]  nbits;
    logic        sck_d;
    logic [7:0]  rd;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         sck_o;
    wire         sck_oe;
    wire         dl_o;
    wire         dl_oe;
    wire         rx_irq_req;
    wire         tx_irq_req;
    wire         far_sck;
    wire         far_dl;
    wire  [8:0]  got;
    wire         busy;
    wire         sck_w = sck_oe ? sck_o : far_sck;
    wire         dl_w = dl_oe ? dl_o : far_dl;
    int          err_count;
    int          comparisons;
    int          rises;
    int          snap;
    usr_sync_port dut (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .core_sleep(core_sleep), .shift_clock_pin_i(sck_w),
        .shift_clock_pin_o(sck_o), .shift_clock_pin_oe(sck_oe), .data_line_pin_i(dl_w),
        .data_line_pin_o(dl_o), .data_line_pin_oe(dl_oe), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req));
    usr_far_end far (.mclk(mclk), .sclk_in(sck_w), .dl_in(dl_w), .drive(drive), .stream(stream), .go(go),
        .nbits(nbits), .sclk_out(far_sck), .dl_out(far_dl), .got(got), .busy(busy));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    // Counts rising shift clock edges on the wire
    always @(posedge mclk) begin
        sck_d <= sck_w;
        if (sck_w && !sck_d) rises <= rises + 1;
    end
    task automatic summarize;
        $display("Comparisons %0d, errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tmo;
        err_count++;
        $display("Error at %0t: wait timed out", $time);
        summarize;
    endtask
    task automatic wait_rdy;
        int i;
        for (i = 0; i < 50; i++) begin
            @(posedge mclk);
            if (hreadyout === 1'b1) break;
        end
        if (i == 50) tmo;
    endtask
    // Address phase held until ready, then data phase held until ready again
    task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        haddr <= {22'h0, idx, 2'h0};
        hwrite <= w;
        htrans <= 2'h2;
        wait_rdy;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        wait_rdy;
        // Select stays up with an idle transfer so back-to-back calls never assign it twice in one step
        rd = hrdata[7:0];
    endtask
    task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, idx, 8'h00);
        chk({24'h0, rd}, {24'h0, exp});
    endtask
    task automatic frame;
        int i;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (busy === 1'b1 && i < 400);
        if (i == 400) tmo;
    endtask
    task automatic t_reset;
        rdchk(`USR_IDX_FLAGS, 8'h02);
        rdchk(`USR_IDX_ENABLES, 8'h00);
        rdchk(`USR_IDX_TRANSMIT_STATUS_REGISTER, 8'h02);
        xfer(1'b1, 8'h20, 8'hff);
        rdchk(8'h20, 8'h00);
        chk(hresp, 1'b0);
    endtask
    // Four nine-bit words into a two-deep queue: third overruns, later ones are blocked
    task automatic t_master_rx;
        xfer(1'b1, `USR_IDX_BAUD, 8'h03);
        xfer(1'b1, `USR_IDX_TRANSMIT_STATUS_REGISTER, 8'h90);
        xfer(1'b1, `USR_IDX_ENABLES, 8'h01);
        stream <= {9'h0c3, 9'h1ff, 9'h05a, 9'h1a5, 1'b0};
        // Far side reloads its stream only while released
        repeat (2) @(posedge mclk);
        drive <= 1'b1;
        xfer(1'b1, `USR_IDX_RECEIVE_STATUS_REGISTER, 8'hd0);
        repeat (330) @(posedge mclk);
        chk(sck_oe, 1'b1);
        chk(rx_irq_req, 1'b1);
        rdchk(`USR_IDX_RECEIVE_STATUS_REGISTER, 8'hd3);
        rdchk(`USR_IDX_RCDATA, 8'ha5);
        rdchk(`USR_IDX_RECEIVE_STATUS_REGISTER, 8'hd2);
        rdchk(`USR_IDX_RCDATA, 8'h5a);
        repeat (90) @(posedge mclk);
        rdchk(`USR_IDX_FLAGS, 8'h02);
        chk(rx_irq_req, 1'b0);
        xfer(1'b1, `USR_IDX_RECEIVE_STATUS_REGISTER, 8'hc0);
        xfer(1'b0, `USR_IDX_RECEIVE_STATUS_REGISTER, 8'h00);
        chk({24'h0, rd & 8'hfe}, 32'hc0);
    endtask
    task automatic t_single;
        drive <= 1'b0;
        stream <= {28'h0, 8'h3c, 1'b0};
        repeat (2) @(posedge mclk);
        drive <= 1'b1;
        snap = rises;
        xfer(1'b1, `USR_IDX_RECEIVE_STATUS_REGISTER, 8'ha0);
        repeat (120) @(posedge mclk);
        chk(rises - snap, 8);
        rdchk(`USR_IDX_RECEIVE_STATUS_REGISTER, 8'h80);
        rdchk(`USR_IDX_RCDATA, 8'h3c);
        xfer(1'b1, `USR_IDX_RECEIVE_STATUS_REGISTER, 8'hb0);
        repeat (150) @(posedge mclk);
        chk(rises - snap > 16, 1'b1);
        xfer(1'b1, `USR_IDX_RECEIVE_STATUS_REGISTER, 8'h80);
        repeat (20) @(posedge mclk);
        snap = rises;
        repeat (60) @(posedge mclk);
        chk(rises, snap);
        xfer(1'b0, `USR_IDX_RCDATA, 8'h00);
        xfer(1'b0, `USR_IDX_RCDATA, 8'h00);
    endtask
    // Two words queued, core asleep, far side clocks them out one frame at a time
    task automatic t_slave_tx;
        drive <= 1'b0;
        nbits <= 4'h8;
        xfer(1'b1, `USR_IDX_TRANSMIT_STATUS_REGISTER, 8'h10);
        xfer(1'b1, `USR_IDX_ENABLES, 8'h02);
        xfer(1'b1, `USR_IDX_TXHOLD, 8'h96);
        xfer(1'b1, `USR_IDX_TRANSMIT_STATUS_REGISTER, 8'h30);
        xfer(1'b1, `USR_IDX_TXHOLD, 8'h4b);
        core_sleep <= 1'b1;
        rdchk(`USR_IDX_FLAGS, 8'h00);
        chk(sck_oe, 1'b0);
        frame;
        chk(got[8:1], 8'h96);
        rdchk(`USR_IDX_FLAGS, 8'h02);
        chk(tx_irq_req, 1'b1);
        frame;
        chk(got[8:1], 8'h4b);
        xfer(1'b1, `USR_IDX_TRANSMIT_STATUS_REGISTER, 8'h10);
        repeat (2) @(posedge mclk);
        chk(dl_oe, 1'b0);
        core_sleep <= 1'b0;
    endtask
    initial begin
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        core_sleep = 1'b0;
        drive = 1'b0;
        stream = 37'h0;
        go = 1'b0;
        nbits = 4'h8;
        repeat (12) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_master_rx;
        t_single;
        t_slave_tx;
        summarize;
    end
endmodule // test_usr_sync_port
bind usr_sync_port usr_sync_port_assertions u_chk (.mclk(mclk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
    .shift_clock_pin_o(shift_clock_pin_o), .shift_clock_pin_oe(shift_clock_pin_oe),
    .data_line_pin_oe(data_line_pin_oe), .rx_irq_req(rx_irq_req), .tx_irq_req(tx_irq_req));
`default_nettype wire
